// [rtl/ulfa_pkg.sv]
package ulfa_pkg;
  localparam int CLK_KHZ = 40_000;
  localparam int LOS_MS = 480;
  localparam int DEA_SHORT_MS = 40;
  localparam int DEA_LONG_MS = 480;
  localparam int ACT_TIMEOUT_S = 15;
  localparam int TONE_HZ = 10_000;
  localparam int LOS_CYC = LOS_MS * CLK_KHZ;
  localparam int DEA_SHORT_CYC = DEA_SHORT_MS * CLK_KHZ;
  localparam int DEA_LONG_CYC = DEA_LONG_MS * CLK_KHZ;
  localparam int ACT_TIMEOUT_CYC = ACT_TIMEOUT_S * 1000 * CLK_KHZ;
  localparam int TRAIN_CYC = 4000;
  // Half period of the wake tone, with a +-20 % acceptance window
  localparam int TONE_HALF_CYC = (CLK_KHZ * 1000) / (2 * TONE_HZ);
  localparam int TONE_MIN_CYC = (TONE_HALF_CYC * 4) / 5;
  localparam int TONE_MAX_CYC = (TONE_HALF_CYC * 6) / 5;
  localparam logic [3:0] TONE_GOOD_HALVES = 4'h8;
  localparam logic [7:0] FRAME_LAST = 8'hef;
  localparam logic [7:0] SYNC_LAST = 8'h11;
  localparam logic [7:0] USER_END = 8'hea;
  localparam logic [7:0] M_FIRST = 8'hea;
  localparam logic [7:0] M4_POS = 8'hed;
  localparam logic [2:0] SF_LAST = 3'h7;
  localparam logic [1:0] SYNC_CONFIRM = 2'h2;
  localparam logic [17:0] NORMAL_SYNCWORD = 18'h2808a;
  localparam logic [17:0] INVERTED_SYNCWORD = 18'h02a20;
  localparam logic [17:0] SIGN_MASK = 18'h2aaaa;
  localparam int SCR_LEN = 23;
  localparam int SCR_TAP_A = 17;
  localparam int SCR_TAP_B = 22;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CMD = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;
  localparam logic [11:0] ADDR_TX_M4 = 12'h00c;
  localparam logic [11:0] ADDR_TX_EOC = 12'h010;
  localparam logic [11:0] ADDR_TX_SPARE = 12'h014;
  localparam logic [11:0] ADDR_RX_OH = 12'h018;
  localparam int CMD_ACT = 0;
  localparam int CMD_DEACT = 1;
  localparam int CMD_CONT = 2;
  localparam int STAT_TONE = 8;
  localparam logic [7:0] TX_M4_RST = 8'hff;
  localparam logic [11:0] TX_EOC_RST = 12'hfff;
  localparam logic [2:0] TX_SPARE_RST = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic sfs_dir_rx;
    logic sfs_en;
    logic bp_sync;
    logic bp_train;
    logic warm_start;
    logic pwr_down;
  } ulfa_ctrl_t;

  localparam ulfa_ctrl_t CTRL_RST = '0;

  typedef enum logic [2:0] {
    SQ_RESET, SQ_IDLE, SQ_TRAIN, SQ_HUNT, SQ_PAUSE, SQ_ACTIVE, SQ_DEA_WARN, SQ_DEA_WAIT
  } ulfa_seq_t;
endpackage : ulfa_pkg

// [rtl/ulfa_scrambler.sv]
`timescale 1ns/1ps
module ulfa_scrambler #(
  parameter bit DESCRAMBLE = 1'b0
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic en_i,
  input wire logic bit_i,
  output logic bit_o
);
  logic [ulfa_pkg::SCR_LEN-1:0] sr;
  logic [ulfa_pkg::SCR_LEN-1:0] next_sr;
  logic fb;

  // Self-synchronising: the descrambler shifts in what arrived on the line
  always_comb
  begin
    fb = sr[ulfa_pkg::SCR_TAP_A] ^ sr[ulfa_pkg::SCR_TAP_B];
    bit_o = bit_i ^ fb;
    next_sr = sr;
    if (en_i)
    begin
      next_sr = {sr[ulfa_pkg::SCR_LEN-2:0], DESCRAMBLE ? bit_i : bit_o};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sr <= '0;
    end
    else
    begin
      sr <= next_sr;
    end
  end
endmodule : ulfa_scrambler

// [rtl/ulfa_core.sv]
`timescale 1ns/1ps
// Behaviour
// R1: Multiplex, then scramble, then add syncword
// R2: Flywheel search and lock on syncwords
// R3: Keep lock until 480 ms errored sync
// R4: Loss of sync: stop transmit, reset
// R5: Detect and correct inverted line polarity
// R6: Descramble and demultiplex while synchronised
// R7: Wake tone detector on while deactivated
// R8: Tone raises flag; low pin if powered down
// R9: Controller answers wake-up with activation commands
// R10: Sequencer runs cold and warm start
// R11: Only activate/deactivate commands, optional breakpoints
// R12: Sequencer drives act and dea bits
// R13: Deactivation uses 40 ms and 480 ms
// R14: 15 s timer abandons failed activation
// R15: Overhead writes apply from next (half-)superframe
// R16: Marker pin flags superframe start, one direction
// R17: Frame one inverted syncword, others normal
// R18: Frame: sync, user data, six overhead bits
module ulfa_core #(
  parameter int LOS_CYCLES = ulfa_pkg::LOS_CYC,
  parameter int DEA_SHORT_CYCLES = ulfa_pkg::DEA_SHORT_CYC,
  parameter int DEA_LONG_CYCLES = ulfa_pkg::DEA_LONG_CYC,
  parameter int ACT_TIMEOUT_CYCLES = ulfa_pkg::ACT_TIMEOUT_CYC,
  parameter int TRAIN_CYCLES = ulfa_pkg::TRAIN_CYC
) (
  input wire logic MCLK_I,
  input wire logic SRST_I,
  input wire logic [11:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [11:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  input wire logic TX_BIT_STB_I,
  input wire logic TX_USER_I,
  output logic TX_USER_TAKE_O,
  output logic TX_BIT_O,
  output logic TX_EN_O,
  input wire logic RX_BIT_STB_I,
  input wire logic RX_BIT_I,
  output logic RX_USER_O,
  output logic RX_USER_STB_O,
  input wire logic LINE_TONE_I,
  output logic WAKE_TONE_DETECT_N_O,
  output logic SUPERFRAME_MARKER_PIN_O
);
  ulfa_pkg::ulfa_ctrl_t ctrl, next_ctrl;
  ulfa_pkg::ulfa_seq_t seq, next_seq, resume, next_resume;
  logic aw_held, next_aw_held, w_held, next_w_held, next_awready, next_wready, next_bvalid;
  logic next_arready, next_rvalid, tone_seen, next_tone_seen;
  logic [11:0] awaddr, next_awaddr;
  logic [31:0] wdata, next_wdata, next_rdata, wval;
  logic [3:0] wstrb, next_wstrb;
  logic [1:0] next_bresp, next_rresp;
  logic [2:0] cmd, next_cmd;
  logic [7:0] tx_m4, next_tx_m4, rx_m4, next_rx_m4;
  logic [11:0] tx_eoc, next_tx_eoc;
  logic [2:0] tx_spare, next_tx_spare;
  logic wr_fire, ok_addr, rok;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  logic locked, rx_far_act, pol_inv, tone_evt, sf_rx;

  // Register slave; read answers one cycle after its handshake, write two cycles after the last handshake
  always_comb
  begin
    next_aw_held = aw_held | (AWVALID_I & AWREADY_O);
    next_w_held = w_held | (WVALID_I & WREADY_O);
    next_awaddr = (AWVALID_I & AWREADY_O) ? AWADDR_I : awaddr;
    next_wdata = (WVALID_I & WREADY_O) ? WDATA_I : wdata;
    next_wstrb = (WVALID_I & WREADY_O) ? WSTRB_I : wstrb;
    next_bvalid = BVALID_O & ~BREADY_I;
    next_bresp = BRESP_O;
    next_ctrl = ctrl;
    next_tx_m4 = tx_m4;
    next_tx_eoc = tx_eoc;
    next_tx_spare = tx_spare;
    next_cmd = '0;
    next_tone_seen = tone_seen;
    wr_fire = aw_held & w_held & ~BVALID_O;
    wval = merge(32'h0000_0000, wdata, wstrb);
    ok_addr = awaddr inside {ulfa_pkg::ADDR_CTRL, ulfa_pkg::ADDR_CMD, ulfa_pkg::ADDR_STAT,
                             ulfa_pkg::ADDR_TX_M4, ulfa_pkg::ADDR_TX_EOC,
                             ulfa_pkg::ADDR_TX_SPARE, ulfa_pkg::ADDR_RX_OH};
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = ok_addr ? ulfa_pkg::RESP_OKAY : ulfa_pkg::RESP_SLVERR;
      unique case (awaddr)
        ulfa_pkg::ADDR_CTRL: next_ctrl = 6'(merge(32'(ctrl), wdata, wstrb));
        ulfa_pkg::ADDR_CMD: next_cmd = wval[2:0]; // R11
        ulfa_pkg::ADDR_STAT: next_tone_seen = tone_seen & ~wval[ulfa_pkg::STAT_TONE];
        ulfa_pkg::ADDR_TX_M4: next_tx_m4 = 8'(merge(32'(tx_m4), wdata, wstrb));
        ulfa_pkg::ADDR_TX_EOC: next_tx_eoc = 12'(merge(32'(tx_eoc), wdata, wstrb));
        ulfa_pkg::ADDR_TX_SPARE: next_tx_spare = 3'(merge(32'(tx_spare), wdata, wstrb));
        default: next_bresp = ok_addr ? ulfa_pkg::RESP_OKAY : ulfa_pkg::RESP_SLVERR;
      endcase
    end
    if (tone_evt)
    begin
      next_tone_seen = 1'b1; // R8
    end
    next_awready = ~next_aw_held & ~next_bvalid;
    next_wready = ~next_w_held & ~next_bvalid;
    next_rvalid = RVALID_O & ~RREADY_I;
    next_rdata = RDATA_O;
    next_rresp = RRESP_O;
    rok = 1'b1;
    if (ARVALID_I & ARREADY_O)
    begin
      next_rvalid = 1'b1;
      unique case (ARADDR_I)
        ulfa_pkg::ADDR_CTRL: next_rdata = 32'(ctrl);
        ulfa_pkg::ADDR_STAT: next_rdata = {23'h0, tone_seen, rx_far_act, pol_inv, locked,
                                           TX_EN_O, 1'b0, 3'(seq)};
        ulfa_pkg::ADDR_TX_M4: next_rdata = 32'(tx_m4);
        ulfa_pkg::ADDR_TX_EOC: next_rdata = 32'(tx_eoc);
        ulfa_pkg::ADDR_TX_SPARE: next_rdata = 32'(tx_spare);
        ulfa_pkg::ADDR_RX_OH: next_rdata = 32'(rx_m4);
        ulfa_pkg::ADDR_CMD: next_rdata = 32'h0000_0000;
        default:
        begin
          next_rdata = 32'h0000_0000;
          rok = 1'b0;
        end
      endcase
      next_rresp = rok ? ulfa_pkg::RESP_OKAY : ulfa_pkg::RESP_SLVERR;
    end
    next_arready = ~next_rvalid;
  end

  always_ff @(posedge MCLK_I)
  begin
    if (SRST_I)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr <= '0;
      wdata <= '0;
      wstrb <= '0;
      AWREADY_O <= 1'b0;
      WREADY_O <= 1'b0;
      BVALID_O <= 1'b0;
      BRESP_O <= ulfa_pkg::RESP_OKAY;
      ARREADY_O <= 1'b0;
      RVALID_O <= 1'b0;
      RDATA_O <= '0;
      RRESP_O <= ulfa_pkg::RESP_OKAY;
      ctrl <= ulfa_pkg::CTRL_RST;
      cmd <= '0;
      tone_seen <= 1'b0;
      tx_m4 <= ulfa_pkg::TX_M4_RST;
      tx_eoc <= ulfa_pkg::TX_EOC_RST;
      tx_spare <= ulfa_pkg::TX_SPARE_RST;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      awaddr <= next_awaddr;
      wdata <= next_wdata;
      wstrb <= next_wstrb;
      AWREADY_O <= next_awready;
      WREADY_O <= next_wready;
      BVALID_O <= next_bvalid;
      BRESP_O <= next_bresp;
      ARREADY_O <= next_arready;
      RVALID_O <= next_rvalid;
      RDATA_O <= next_rdata;
      RRESP_O <= next_rresp;
      ctrl <= next_ctrl;
      cmd <= next_cmd;
      tone_seen <= next_tone_seen;
      tx_m4 <= next_tx_m4;
      tx_eoc <= next_tx_eoc;
      tx_spare <= next_tx_spare;
    end
  end

  // Wake tone: eight consecutive half periods inside the window
  logic tone_q, next_tone_q, det_on, next_wake_n;
  logic [11:0] tone_cnt, next_tone_cnt;
  logic [3:0] tone_good, next_tone_good;
  always_comb
  begin
    det_on = (seq == ulfa_pkg::SQ_IDLE) | (seq == ulfa_pkg::SQ_RESET); // R7
    next_tone_q = LINE_TONE_I;
    next_tone_cnt = (tone_cnt == 12'hfff) ? tone_cnt : tone_cnt + 12'h001;
    next_tone_good = tone_good;
    tone_evt = 1'b0;
    if (LINE_TONE_I != tone_q)
    begin
      next_tone_cnt = 12'h000;
      next_tone_good = 4'h0;
      if ((32'(tone_cnt) >= ulfa_pkg::TONE_MIN_CYC) && (32'(tone_cnt) <= ulfa_pkg::TONE_MAX_CYC))
      begin
        next_tone_good = tone_good + 4'h1;
        if (next_tone_good == ulfa_pkg::TONE_GOOD_HALVES)
        begin
          tone_evt = det_on; // R7
          next_tone_good = 4'h0;
        end
      end
    end
    if (!det_on)
    begin
      next_tone_good = 4'h0;
    end
    next_wake_n = ~(next_tone_seen & ctrl.pwr_down); // R8
  end

  always_ff @(posedge MCLK_I)
  begin
    if (SRST_I)
    begin
      tone_q <= 1'b0;
      tone_cnt <= '0;
      tone_good <= '0;
      WAKE_TONE_DETECT_N_O <= 1'b1;
    end
    else
    begin
      tone_q <= next_tone_q;
      tone_cnt <= next_tone_cnt;
      tone_good <= next_tone_good;
      WAKE_TONE_DETECT_N_O <= next_wake_n;
    end
  end

  // Activation sequencer; one timer for phases, one for the whole activation
  logic [31:0] tmr, next_tmr, act_tmr, next_act_tmr;
  logic los_evt, act_bit, dea_bit, next_tx_en;
  always_comb
  begin
    next_seq = seq;
    next_resume = resume;
    next_tmr = (tmr != 32'h0) ? tmr - 32'h1 : tmr;
    next_act_tmr = (act_tmr != 32'h0) ? act_tmr - 32'h1 : act_tmr;
    unique case (seq)
      ulfa_pkg::SQ_RESET: next_seq = ulfa_pkg::SQ_IDLE;
      ulfa_pkg::SQ_IDLE:
        if (cmd[ulfa_pkg::CMD_ACT]) // R9
        begin
          next_act_tmr = 32'(ACT_TIMEOUT_CYCLES); // R14
          next_tmr = 32'(TRAIN_CYCLES);
          next_seq = ctrl.warm_start ? ulfa_pkg::SQ_HUNT : ulfa_pkg::SQ_TRAIN; // R10
        end
      ulfa_pkg::SQ_TRAIN:
        if (tmr == 32'h0)
        begin
          next_resume = ulfa_pkg::SQ_HUNT;
          next_seq = ctrl.bp_train ? ulfa_pkg::SQ_PAUSE : ulfa_pkg::SQ_HUNT; // R11
        end
      ulfa_pkg::SQ_HUNT:
        if (locked)
        begin
          next_resume = ulfa_pkg::SQ_ACTIVE;
          next_seq = ctrl.bp_sync ? ulfa_pkg::SQ_PAUSE : ulfa_pkg::SQ_ACTIVE; // R11
        end
      ulfa_pkg::SQ_PAUSE:
        if (cmd[ulfa_pkg::CMD_CONT])
        begin
          next_seq = resume;
        end
      ulfa_pkg::SQ_ACTIVE: next_seq = seq;
      ulfa_pkg::SQ_DEA_WARN:
        if (tmr == 32'h0)
        begin
          next_tmr = 32'(DEA_LONG_CYCLES); // R13
          next_seq = ulfa_pkg::SQ_DEA_WAIT;
        end
      ulfa_pkg::SQ_DEA_WAIT:
        if (tmr == 32'h0)
        begin
          next_seq = ulfa_pkg::SQ_IDLE;
        end
    endcase
    // A stalled handshake cannot hold the loop half-active
    if ((seq inside {ulfa_pkg::SQ_TRAIN, ulfa_pkg::SQ_HUNT, ulfa_pkg::SQ_PAUSE})
        && act_tmr == 32'h0)
    begin
      next_seq = ulfa_pkg::SQ_RESET; // R14
    end
    if (cmd[ulfa_pkg::CMD_DEACT] && (seq inside {ulfa_pkg::SQ_TRAIN, ulfa_pkg::SQ_HUNT,
        ulfa_pkg::SQ_PAUSE, ulfa_pkg::SQ_ACTIVE}))
    begin
      next_tmr = 32'(DEA_SHORT_CYCLES); // R13
      next_seq = ulfa_pkg::SQ_DEA_WARN;
    end
    if (los_evt)
    begin
      next_seq = ulfa_pkg::SQ_RESET; // R4
    end
    next_tx_en = next_seq inside {ulfa_pkg::SQ_TRAIN, ulfa_pkg::SQ_HUNT, ulfa_pkg::SQ_PAUSE,
                                  ulfa_pkg::SQ_ACTIVE, ulfa_pkg::SQ_DEA_WARN}; // R4
    act_bit = (seq == ulfa_pkg::SQ_ACTIVE); // R12
    dea_bit = (seq != ulfa_pkg::SQ_DEA_WARN); // R12
  end

  always_ff @(posedge MCLK_I)
  begin
    if (SRST_I)
    begin
      seq <= ulfa_pkg::SQ_RESET;
      resume <= ulfa_pkg::SQ_HUNT;
      tmr <= '0;
      act_tmr <= '0;
      TX_EN_O <= 1'b0;
    end
    else
    begin
      seq <= next_seq;
      resume <= next_resume;
      tmr <= next_tmr;
      act_tmr <= next_act_tmr;
      TX_EN_O <= next_tx_en;
    end
  end

  // Transmit framer
  logic [7:0] tx_pos, next_tx_pos, sh_m4, next_sh_m4;
  logic [2:0] tx_frm, next_tx_frm, sh_spare, next_sh_spare;
  logic [11:0] sh_eoc, next_sh_eoc;
  logic payload, scr_bit, line_bit, next_tx_bit, next_take, tx_scr_en, next_sfs;
  logic [2:0] m_idx;
  logic [3:0] e_idx;
  always_comb
  begin
    m_idx = 3'(tx_pos - ulfa_pkg::M_FIRST);
    e_idx = 4'(({2'b00, tx_frm[1:0]} * 4'h3) + {2'b00, m_idx[1:0]});
    payload = 1'b1;
    if (tx_pos < ulfa_pkg::USER_END)
    begin
      payload = TX_USER_I; // R18
    end
    else if (m_idx < 3'h3)
    begin
      payload = sh_eoc[e_idx];
    end
    else if (m_idx == 3'h3)
    begin
      payload = (tx_frm == 3'h0) ? act_bit : (tx_frm == 3'h1) ? dea_bit : sh_m4[tx_frm]; // R12
    end
    else if (tx_frm == 3'h0)
    begin
      payload = sh_spare[m_idx[0]];
    end
    else if (tx_frm == 3'h1 && m_idx == 3'h4)
    begin
      payload = sh_spare[2];
    end
    tx_scr_en = TX_BIT_STB_I & (tx_pos > ulfa_pkg::SYNC_LAST); // R1
    line_bit = (tx_pos > ulfa_pkg::SYNC_LAST) ? scr_bit :
               (tx_frm == 3'h0) ? ulfa_pkg::INVERTED_SYNCWORD[5'd17 - tx_pos[4:0]] // R17
                                : ulfa_pkg::NORMAL_SYNCWORD[5'd17 - tx_pos[4:0]];
    next_tx_pos = tx_pos;
    next_tx_frm = tx_frm;
    next_sh_m4 = sh_m4;
    next_sh_eoc = sh_eoc;
    next_sh_spare = sh_spare;
    next_tx_bit = TX_BIT_O & TX_EN_O; // R4
    next_take = 1'b0;
    if (TX_BIT_STB_I)
    begin
      next_tx_bit = TX_EN_O & line_bit; // R4
      next_take = TX_EN_O & (tx_pos > ulfa_pkg::SYNC_LAST) & (tx_pos < ulfa_pkg::USER_END);
      next_tx_pos = (tx_pos == ulfa_pkg::FRAME_LAST) ? 8'h00 : tx_pos + 8'h01;
      if (tx_pos == ulfa_pkg::FRAME_LAST)
      begin
        next_tx_frm = tx_frm + 3'h1;
        if (tx_frm[1:0] == 2'h3)
        begin
          next_sh_eoc = tx_eoc; // R15
        end
        if (tx_frm == ulfa_pkg::SF_LAST)
        begin
          next_sh_m4 = tx_m4; // R15
          next_sh_spare = tx_spare; // R15
        end
      end
    end
    next_sfs = ctrl.sfs_en & (ctrl.sfs_dir_rx ? sf_rx : // R16
               (TX_BIT_STB_I & tx_pos == 8'h00 & tx_frm == 3'h0));
  end

  ulfa_scrambler #(.DESCRAMBLE(1'b0)) u_scr (
    .clk_i(MCLK_I),
    .srst_i(SRST_I),
    .en_i(tx_scr_en),
    .bit_i(payload),
    .bit_o(scr_bit)
  );

  always_ff @(posedge MCLK_I)
  begin
    if (SRST_I)
    begin
      tx_pos <= '0;
      tx_frm <= '0;
      sh_m4 <= ulfa_pkg::TX_M4_RST;
      sh_eoc <= ulfa_pkg::TX_EOC_RST;
      sh_spare <= ulfa_pkg::TX_SPARE_RST;
      TX_BIT_O <= 1'b0;
      TX_USER_TAKE_O <= 1'b0;
      SUPERFRAME_MARKER_PIN_O <= 1'b0;
    end
    else
    begin
      tx_pos <= next_tx_pos;
      tx_frm <= next_tx_frm;
      sh_m4 <= next_sh_m4;
      sh_eoc <= next_sh_eoc;
      sh_spare <= next_sh_spare;
      TX_BIT_O <= next_tx_bit;
      TX_USER_TAKE_O <= next_take;
      SUPERFRAME_MARKER_PIN_O <= next_sfs;
    end
  end

  // Receive sync; hunting only on the superframe word fixes frame numbering too
  logic [17:0] win, next_win, win_n, exp_w;
  logic [7:0] rx_pos, next_rx_pos, rx_acc, next_rx_acc;
  logic [2:0] rx_frm, next_rx_frm;
  logic [1:0] good, next_good;
  logic aligned, next_aligned, next_locked, next_pol, err_run, next_err_run, hit;
  logic [31:0] los_cnt, next_los_cnt;
  logic cbit, dbit, rx_dscr_en, next_ruser, next_rstb, next_far_act;
  always_comb
  begin
    win_n = {win[16:0], RX_BIT_I};
    exp_w = (rx_frm == 3'h0) ? ulfa_pkg::INVERTED_SYNCWORD : ulfa_pkg::NORMAL_SYNCWORD;
    hit = (win_n == (pol_inv ? exp_w ^ ulfa_pkg::SIGN_MASK : exp_w)); // R2
    cbit = RX_BIT_I ^ (pol_inv & ~rx_pos[0]); // R5
    next_win = RX_BIT_STB_I ? win_n : win;
    next_rx_pos = rx_pos;
    next_rx_frm = rx_frm;
    next_good = good;
    next_aligned = aligned;
    next_locked = locked;
    next_pol = pol_inv;
    next_err_run = err_run;
    next_rx_acc = rx_acc;
    next_rx_m4 = rx_m4;
    next_far_act = rx_far_act;
    next_ruser = RX_USER_O;
    next_rstb = 1'b0;
    los_evt = 1'b0;
    sf_rx = 1'b0;
    rx_dscr_en = RX_BIT_STB_I & locked & (rx_pos > ulfa_pkg::SYNC_LAST); // R6
    if (RX_BIT_STB_I && !aligned)
    begin
      if (win_n == ulfa_pkg::INVERTED_SYNCWORD ||
          win_n == (ulfa_pkg::INVERTED_SYNCWORD ^ ulfa_pkg::SIGN_MASK))
      begin
        next_aligned = 1'b1;
        next_pol = (win_n != ulfa_pkg::INVERTED_SYNCWORD); // R5
        next_rx_pos = ulfa_pkg::SYNC_LAST + 8'h01;
        next_rx_frm = 3'h0;
        next_good = 2'h1;
      end
    end
    else if (RX_BIT_STB_I)
    begin
      next_rx_pos = (rx_pos == ulfa_pkg::FRAME_LAST) ? 8'h00 : rx_pos + 8'h01;
      if (rx_pos == ulfa_pkg::FRAME_LAST)
      begin
        next_rx_frm = rx_frm + 3'h1;
      end
      if (rx_pos == ulfa_pkg::SYNC_LAST)
      begin
        sf_rx = locked & hit & (rx_frm == 3'h0);
        if (!locked && hit)
        begin
          next_good = good + 2'h1;
          next_locked = (next_good == ulfa_pkg::SYNC_CONFIRM); // R2
        end
        else if (!locked)
        begin
          next_aligned = 1'b0;
        end
        else
        begin
          next_err_run = ~hit; // R3
        end
      end
      if (locked && rx_pos > ulfa_pkg::SYNC_LAST && rx_pos < ulfa_pkg::USER_END)
      begin
        next_ruser = dbit; // R6
        next_rstb = 1'b1;
      end
      if (locked && rx_pos == ulfa_pkg::M4_POS)
      begin
        next_rx_acc[rx_frm] = dbit;
        if (rx_frm == 3'h0)
        begin
          next_far_act = dbit;
        end
        if (rx_frm == ulfa_pkg::SF_LAST)
        begin
          next_rx_m4 = {dbit, rx_acc[6:0]};
        end
      end
    end
    // Errored sync must persist, unbroken by a good word, for the whole interval
    next_los_cnt = (locked & next_err_run) ? los_cnt + 32'h1 : 32'h0;
    if (locked && next_err_run && los_cnt == 32'(LOS_CYCLES - 1))
    begin
      los_evt = 1'b1; // R4
      next_locked = 1'b0; // R3
      next_aligned = 1'b0;
      next_err_run = 1'b0;
      next_los_cnt = 32'h0;
    end
  end

  ulfa_scrambler #(.DESCRAMBLE(1'b1)) u_dscr (
    .clk_i(MCLK_I),
    .srst_i(SRST_I),
    .en_i(rx_dscr_en),
    .bit_i(cbit),
    .bit_o(dbit)
  );

  always_ff @(posedge MCLK_I)
  begin
    if (SRST_I)
    begin
      win <= '0;
      rx_pos <= '0;
      rx_frm <= '0;
      good <= '0;
      aligned <= 1'b0;
      locked <= 1'b0;
      pol_inv <= 1'b0;
      err_run <= 1'b0;
      los_cnt <= '0;
      rx_acc <= '0;
      rx_m4 <= '0;
      rx_far_act <= 1'b0;
      RX_USER_O <= 1'b0;
      RX_USER_STB_O <= 1'b0;
    end
    else
    begin
      win <= next_win;
      rx_pos <= next_rx_pos;
      rx_frm <= next_rx_frm;
      good <= next_good;
      aligned <= next_aligned;
      locked <= next_locked;
      pol_inv <= next_pol;
      err_run <= next_err_run;
      los_cnt <= next_los_cnt;
      rx_acc <= next_rx_acc;
      rx_m4 <= next_rx_m4;
      rx_far_act <= next_far_act;
      RX_USER_O <= next_ruser;
      RX_USER_STB_O <= next_rstb;
    end
  end
endmodule : ulfa_core

// [tb/ulfa_core_assertions.sv]
`timescale 1ns/1ps
module ulfa_core_assertions (
  input wire logic MCLK_I,
  input wire logic SRST_I,
  input wire logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [1:0] BRESP_O,
  input wire logic RVALID_O,
  input wire logic RREADY_I,
  input wire logic [31:0] RDATA_O,
  input wire logic TX_EN_O,
  input wire logic TX_BIT_O,
  input wire logic TX_BIT_STB_I,
  input wire logic TX_USER_TAKE_O,
  input wire logic RX_BIT_STB_I,
  input wire logic RX_USER_STB_O,
  input wire logic WAKE_TONE_DETECT_N_O,
  input wire logic SUPERFRAME_MARKER_PIN_O
);
  default clocking ck @(posedge MCLK_I);
  endclocking
  default disable iff (SRST_I);
  sequence s_mark;
    SUPERFRAME_MARKER_PIN_O ##1 !SUPERFRAME_MARKER_PIN_O [*8];
  endsequence
  rst_quiet_a: assert property ($fell(SRST_I) |-> !TX_EN_O && WAKE_TONE_DETECT_N_O)
    else $error("line or tone pin active after reset");
  b_hold_a: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
    else $error("write response not held");
  r_hold_a: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
    else $error("read data not held");
  tx_silent_a: assert property (!TX_EN_O && !$past(TX_EN_O) |-> !TX_BIT_O)
    else $error("line bit while transmit off");
  take_cause_a: assert property (TX_USER_TAKE_O |-> $past(TX_BIT_STB_I))
    else $error("user bit taken without slot");
  take_pulse_a: assert property (TX_USER_TAKE_O |=> !TX_USER_TAKE_O [*3])
    else $error("user take too long");
  rx_cause_a: assert property (RX_USER_STB_O |-> $past(RX_BIT_STB_I))
    else $error("receive strobe without line bit");
  marker_pulse_a: assert property ($rose(SUPERFRAME_MARKER_PIN_O) |-> s_mark)
    else $error("marker not a single pulse");
endmodule : ulfa_core_assertions
bind ulfa_core ulfa_core_assertions u_chk (.*);

// [tb/ulfa_far_end.sv]
`timescale 1ns/1ps
module ulfa_far_end (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic kill_i,
  output logic stb_o,
  output logic bit_o
);
  logic [1:0] div;
  logic [7:0] pos;
  logic [2:0] frm;
  logic [17:0] sw;
  assign sw = (frm == 3'h0) ? ulfa_pkg::INVERTED_SYNCWORD : ulfa_pkg::NORMAL_SYNCWORD;
  // Slot every fourth clock; kill_i spoils syncwords to force a loss of sync
  always @(posedge clk_i)
  begin
    div <= div + 2'h1;
    stb_o <= div == 2'h3 && !srst_i;
    if (div == 2'h3)
    begin
      bit_o <= pos <= 8'h11 ? sw[5'h11 - pos[4:0]] ^ kill_i : pos[0];
      pos <= pos == 8'hef ? 8'h00 : pos + 8'h01;
      frm <= pos == 8'hef ? frm + 3'h1 : frm;
    end
    if (srst_i)
    begin
      div <= 2'h0;
      pos <= 8'h00;
      frm <= 3'h0;
    end
  end
endmodule : ulfa_far_end

// [tb/test_ulfa_core.sv]
`timescale 1ns/1ps
module test_ulfa_core;
  logic MCLK_I = 1'b0, SRST_I = 1'b1, AWVALID_I = 1'b0, WVALID_I = 1'b0, BREADY_I = 1'b0;
  logic ARVALID_I = 1'b0, RREADY_I = 1'b0, LINE_TONE_I = 1'b0, kill = 1'b0;
  logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, RX_USER_O, RX_USER_STB_O, TX_EN_O;
  logic TX_USER_TAKE_O, TX_BIT_O, WAKE_TONE_DETECT_N_O, SUPERFRAME_MARKER_PIN_O;
  logic RX_BIT_STB_I, RX_BIT_I;
  logic [11:0] AWADDR_I = 12'h000, ARADDR_I = 12'h000;
  logic [31:0] WDATA_I = 32'h0, RDATA_O, d;
  logic [1:0] BRESP_O, RRESP_O;
  wire [3:0] WSTRB_I = 4'hf;
  wire TX_USER_I = 1'b0;
  wire TX_BIT_STB_I = RX_BIT_STB_I;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  realtime t0;
  ulfa_core #(.LOS_CYCLES(2000), .DEA_SHORT_CYCLES(300), .DEA_LONG_CYCLES(500),
    .ACT_TIMEOUT_CYCLES(20000), .TRAIN_CYCLES(50)) u_dut (.*);
  ulfa_far_end u_far (.clk_i(MCLK_I), .srst_i(SRST_I), .kill_i(kill), .stb_o(RX_BIT_STB_I),
    .bit_o(RX_BIT_I));
  always #12.5 MCLK_I = ~MCLK_I;
  always @(posedge MCLK_I)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // One generic access; an edge passes first so no strobe is assigned twice in a step
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] v, logic [1:0] r);
    @(posedge MCLK_I);
    AWADDR_I <= a;
    ARADDR_I <= a;
    WDATA_I <= v;
    AWVALID_I <= w;
    WVALID_I <= w;
    BREADY_I <= w;
    ARVALID_I <= !w;
    RREADY_I <= !w;
    do
    begin
      @(posedge MCLK_I);
      if (AWREADY_O === 1'b1) AWVALID_I <= 1'b0;
      if (WREADY_O === 1'b1) WVALID_I <= 1'b0;
      if (ARREADY_O === 1'b1) ARVALID_I <= 1'b0;
    end while ((w ? BVALID_O : RVALID_O) !== 1'b1);
    BREADY_I <= 1'b0;
    RREADY_I <= 1'b0;
    d = RDATA_O;
    chk({30'h0, w ? BRESP_O : RRESP_O}, {30'h0, r});
  endtask : bus
  task automatic poll(input logic [2:0] s);
    repeat (3000)
    begin
      bus(1'b0, 12'h008, 32'h0, 2'h0);
      if (d[2:0] === s) break;
    end
    chk({29'h0, d[2:0]}, {29'h0, s});
  endtask : poll
  task automatic t_regs;
    bus(1'b0, 12'h00c, 32'h0, 2'h0);
    chk(d, 32'hff);
    bus(1'b1, 12'h01c, 32'h1, 2'h2);
    bus(1'b0, 12'h01c, 32'h0, 2'h2);
    chk(d, 32'h0);
  endtask : t_regs
  task automatic t_tone;
    bus(1'b1, 12'h000, 32'h1, 2'h0);
    repeat (10)
    begin
      repeat (2000) @(posedge MCLK_I);
      LINE_TONE_I <= ~LINE_TONE_I;
    end
    repeat (20) @(posedge MCLK_I);
    chk({31'h0, WAKE_TONE_DETECT_N_O}, 32'h0);
    bus(1'b1, 12'h008, 32'h100, 2'h0);
    repeat (2) @(posedge MCLK_I);
    chk({31'h0, WAKE_TONE_DETECT_N_O}, 32'h1);
  endtask : t_tone
  task automatic t_act;
    bus(1'b1, 12'h000, 32'h12, 2'h0);
    bus(1'b1, 12'h004, 32'h1, 2'h0);
    poll(3'h5);
    chk(d & 32'h30, 32'h30);
  endtask : t_act
  task automatic t_mark;
    repeat (2)
    begin
      @(posedge SUPERFRAME_MARKER_PIN_O);
      t0 = $realtime;
      @(posedge SUPERFRAME_MARKER_PIN_O);
      chk(32'(int'($realtime - t0)), 32'h2ee00);
      bus(1'b1, 12'h000, 32'h32, 2'h0);
    end
  endtask : t_mark
  task automatic t_deact;
    bus(1'b1, 12'h004, 32'h2, 2'h0);
    poll(3'h6);
    poll(3'h7);
    chk({31'h0, TX_EN_O}, 32'h0);
    poll(3'h1);
  endtask : t_deact
  task automatic t_los;
    kill <= 1'b1;
    repeat (1900) @(posedge MCLK_I);
    chk({31'h0, TX_EN_O}, 32'h1);
    repeat (1400) @(posedge MCLK_I);
    chk({31'h0, TX_EN_O}, 32'h0);
  endtask : t_los
  task automatic end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (6) @(posedge MCLK_I);
    SRST_I <= 1'b0;
    t_regs();
    t_tone();
    t_act();
    t_mark();
    t_deact();
    t_act();
    t_los();
    end_of_test();
  end
endmodule : test_ulfa_core
